// File: verilog/pmx_consts.svh
// Register offsets, field layout, reset values and selection codes
// for the Port B / Port C pin-function multiplexer.
// Assumes a 32-bit AHB-Lite slave, one register per aligned word.
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH

// Byte offsets inside the block's window
`define PMX_OFS_PB_SEL_LOW   8'h00
`define PMX_OFS_PB_SEL_HIGH  8'h04
`define PMX_OFS_PC_SEL_LOW   8'h08
`define PMX_OFS_PC_SEL_HIGH  8'h0c
`define PMX_OFS_IN_SRC_SEL   8'h10
`define PMX_ADDR_BITS        8

// Reset values of all selection registers
`define PMX_RST_SEL          8'h00
// Implemented bits of the input source register
`define PMX_IN_SRC_MASK      8'h7f

// Input source field positions
`define PMX_IS_JITTER_BIT    6
`define PMX_IS_IRQ1_BIT      5
`define PMX_IS_IRQ0_BIT      4
`define PMX_IS_DATA_HI       3
`define PMX_IS_DATA_LO       2
`define PMX_IS_SCLK_BIT      1
`define PMX_IS_AUX_BIT       0

// Two-bit function codes
`define PMX_F0               2'h0
`define PMX_F1               2'h1
`define PMX_F2               2'h2
`define PMX_F3               2'h3

// AHB-Lite encodings
`define PMX_HTRANS_NONSEQ    2'h2
`define PMX_HRESP_OKAY       1'b0

`endif

// File: verilog/pmx_pkg.sv
// Types shared by the pin-function multiplexer and its surroundings.
// Assumes the peripherals drive and read these bundles on clk.
`default_nettype none

package pmx_pkg;

	// Outputs of on-chip peripherals that may reach a pad
	typedef struct packed {
		logic timer0_out;
		logic timer0_out_inverted;
		logic timer1_out;
		logic timer1_out_inverted;
		logic timer2_out;
		logic timer3_out;
		logic periodic_timer_out;
		logic peripheral_clock_out;
		logic timer_module_clock_out;
		logic pwm_channel_two_out;
		logic pwm_channel_three_out;
		logic serial_clock_o;
		logic serial_clock_oe;
		logic shared_data_o;
		logic shared_data_oe;
		logic spi_slave_select_o;
		logic spi_slave_select_oe;
		logic sdo_o;
		logic sdo_oe;
	} pmx_periph_out_t;

	// Pad levels routed back to peripheral inputs
	typedef struct packed {
		logic timer0_clock_in;
		logic timer1_clock_in;
		logic timer2_clock_in;
		logic timer3_clock_in;
		logic periodic_timer_clock_in;
		logic periodic_capture_in;
		logic ext_irq_zero_in;
		logic ext_irq_one_in;
		logic jitter_freq_in;
		logic shared_data_in;
		logic serial_clock_in;
		logic serial_aux_in;
	} pmx_periph_in_t;

	// Analog switch enables for the pad-side analog paths
	typedef struct packed {
		logic [7:0] analog_channel;
		logic       opamp_output;
		logic       opamp_inverting_in;
		logic       adc_reference_in;
		logic       phase_detect_pb2;
		logic       phase_detect_pc5;
		logic       overvoltage_comp_in;
		logic       low_voltage_detect_in;
	} pmx_analog_en_t;

endpackage

`default_nettype wire

// File: verilog/pmx_pin_mux.sv
// Pin-function multiplexer for Port B and Port C with an AHB-Lite
// register slave.
// Assumes pads arrive asynchronously; peripherals and port logic on clk.
//
// Functional notes
// - B3: 01 analog 3, else GPIO
// - B2: GPIO, phase, analog 2, reference
// - B1: GPIO, analog 1, opamp, both
// - B0: 01 opamp input, 10 analog 0
// - B7: GPIO, timer2, serial clock, analog 7
// - B6: GPIO, shared data, clock out, analog
// - B5: 01 inverted timer1, 10 analog 5
// - B4: 01 inverted timer0, 10 analog 4
// - C3: 01 overvoltage input; 1x reserved
// - C2: GPIO, timer1, shared data, clock out
// - C1: GPIO, timer0, slave select, data out
// - C0: GPIO, periodic timer, select, data out
// - C6: 01 PWM_CHANNEL_THREE_OUT, else GPIO
// - C5: 01 clock out, 10 phase input
// - C4: GPIO, low voltage, timer3, clock out
// - Source bit 7 reads zero, ignores writes
// - Source bit 6 picks jitter input pin
// - Source bit 5 picks interrupt 1 pin
// - Source bits 3:2 pick shared data pin
// - Source bit 1 picks serial clock pin
`timescale 1ns/10ps
`default_nettype none
`include "pmx_consts.svh"

module pmx_pin_mux
(
	input  wire logic                    clk,
	input  wire logic                    nrst,
	// AHB-Lite slave
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic                         hreadyout,
	output logic                         hresp,
	output logic [31:0]                  hrdata,
	// Port data and control from the GPIO registers
	input  wire logic [7:0]              gpio_b_out,
	input  wire logic [7:0]              gpio_b_oe,
	input  wire logic [7:0]              gpio_c_out,
	input  wire logic [7:0]              gpio_c_oe,
	// Peripheral side
	input  wire pmx_pkg::pmx_periph_out_t periph_out,
	output pmx_pkg::pmx_periph_in_t      periph_in,
	output pmx_pkg::pmx_analog_en_t      analog_en,
	// Pad side
	input  wire logic [7:0]              pad_b_in,
	input  wire logic [7:0]              pad_c_in,
	input  wire logic                    port_a_pin0_in,
	input  wire logic                    port_a_pin2_in,
	output logic [7:0]                   pad_b_out,
	output logic [7:0]                   pad_b_oe,
	output logic [7:0]                   pad_c_out,
	output logic [7:0]                   pad_c_oe,
	// Synchronised pad levels for the port read path
	output logic [7:0]                   port_b_read,
	output logic [7:0]                   port_c_read
);

	// Two-bit function field of pin idx inside an 8-bit register
	function automatic logic [1:0] fld(input logic [7:0] r,
		input logic [1:0] idx);
		fld = r[{idx, 1'b0} +: 2];
	endfunction

	// Four-way selection by function code
	function automatic logic pick4(input logic [1:0] c, input logic a0,
		input logic a1, input logic a2, input logic a3);
		case (c)
			`PMX_F0: pick4 = a0;
			`PMX_F1: pick4 = a1;
			`PMX_F2: pick4 = a2;
			default: pick4 = a3;
		endcase
	endfunction

	// Selection registers
	logic [7:0] port_b_select_low_q;
	logic [7:0] port_b_select_high_q;
	logic [7:0] port_c_select_low_q;
	logic [7:0] port_c_select_high_q;
	logic [7:0] input_source_select_q;

	// Bus data-phase state
	logic                       wr_pend_q;
	logic [`PMX_ADDR_BITS-1:0]  wr_addr_q;
	logic [31:0]                hrdata_q;

	// Pad synchronisers; stage one feeds stage two only
	logic [7:0] pb_s1_q;
	logic [7:0] pb_s2_q;
	logic [7:0] pc_s1_q;
	logic [7:0] pc_s2_q;
	logic [1:0] pa_s1_q;
	logic [1:0] pa_s2_q;

	// Registered pad and peripheral outputs
	logic [7:0]                pad_b_out_q;
	logic [7:0]                pad_b_oe_q;
	logic [7:0]                pad_c_out_q;
	logic [7:0]                pad_c_oe_q;
	pmx_pkg::pmx_periph_in_t   periph_in_q;
	pmx_pkg::pmx_analog_en_t   analog_en_q;

	// Bus decode
	wire                      addr_phase;
	wire [`PMX_ADDR_BITS-1:0] rd_addr;
	wire [7:0]                rd_byte;
	wire                      wr_pb_lo;
	wire                      wr_pb_hi;
	wire                      wr_pc_lo;
	wire                      wr_pc_hi;
	wire                      wr_is;

	assign addr_phase = hsel & hready & (htrans == `PMX_HTRANS_NONSEQ);
	assign rd_addr    = haddr[`PMX_ADDR_BITS-1:0];

	// Unmapped reads return zero; bit 7 of the source register is absent
	assign rd_byte =
		(rd_addr == `PMX_OFS_PB_SEL_LOW)  ? port_b_select_low_q  :
		(rd_addr == `PMX_OFS_PB_SEL_HIGH) ? port_b_select_high_q :
		(rd_addr == `PMX_OFS_PC_SEL_LOW)  ? port_c_select_low_q  :
		(rd_addr == `PMX_OFS_PC_SEL_HIGH) ? port_c_select_high_q :
		(rd_addr == `PMX_OFS_IN_SRC_SEL)  ?
			(input_source_select_q & `PMX_IN_SRC_MASK) : 8'h00;

	// Write strobes in the data phase; only the low byte lane is used
	assign wr_pb_lo = wr_pend_q & (wr_addr_q == `PMX_OFS_PB_SEL_LOW);
	assign wr_pb_hi = wr_pend_q & (wr_addr_q == `PMX_OFS_PB_SEL_HIGH);
	assign wr_pc_lo = wr_pend_q & (wr_addr_q == `PMX_OFS_PC_SEL_LOW);
	assign wr_pc_hi = wr_pend_q & (wr_addr_q == `PMX_OFS_PC_SEL_HIGH);
	assign wr_is    = wr_pend_q & (wr_addr_q == `PMX_OFS_IN_SRC_SEL);

	// Address phase capture and read data; zero wait states
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			hrdata_q  <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_q <= addr_phase & hwrite;
			wr_addr_q <= rd_addr;
			if (addr_phase & ~hwrite)
				hrdata_q <= {24'h00_0000, rd_byte};
		end
	end

	// Selection registers; all clear at reset
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			port_b_select_low_q   <= `PMX_RST_SEL;
			port_b_select_high_q  <= `PMX_RST_SEL;
			port_c_select_low_q   <= `PMX_RST_SEL;
			port_c_select_high_q  <= `PMX_RST_SEL;
			input_source_select_q <= `PMX_RST_SEL;
		end
		else
		begin
			if (wr_pb_lo)
				port_b_select_low_q <= hwdata[7:0];
			if (wr_pb_hi)
				port_b_select_high_q <= hwdata[7:0];
			if (wr_pc_lo)
				port_c_select_low_q <= hwdata[7:0];
			if (wr_pc_hi)
				port_c_select_high_q <= hwdata[7:0];
			if (wr_is)
				input_source_select_q <= hwdata[7:0] & `PMX_IN_SRC_MASK;
		end
	end

	// Per-pin fields: low registers hold pins 3..0, high hold 7..4
	logic [1:0] fb [8];
	logic [1:0] fc [8];

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_fld
			assign fb[gi]   = fld(port_b_select_low_q,  2'(gi));
			assign fb[gi+4] = fld(port_b_select_high_q, 2'(gi));
			assign fc[gi]   = fld(port_c_select_low_q,  2'(gi));
			assign fc[gi+4] = fld(port_c_select_high_q, 2'(gi));
		end
	endgenerate

	// Port B pad drive; analog modes release the digital driver
	wire [7:0] b_out_d;
	wire [7:0] b_oe_d;
	wire [7:0] c_out_d;
	wire [7:0] c_oe_d;
	wire       go;

	assign go = 1'b1;

	assign b_out_d[0] = pick4(fb[0], gpio_b_out[0], 1'b0, 1'b0,
		gpio_b_out[0]);
	assign b_oe_d[0]  = pick4(fb[0], gpio_b_oe[0], 1'b0, 1'b0,
		gpio_b_oe[0]);
	assign b_out_d[1] = pick4(fb[1], gpio_b_out[1], 1'b0, 1'b0, 1'b0);
	assign b_oe_d[1]  = pick4(fb[1], gpio_b_oe[1], 1'b0, 1'b0, 1'b0);
	assign b_out_d[2] = pick4(fb[2], gpio_b_out[2], 1'b0, 1'b0, 1'b0);
	assign b_oe_d[2]  = pick4(fb[2], gpio_b_oe[2], 1'b0, 1'b0, 1'b0);
	assign b_out_d[3] = pick4(fb[3], gpio_b_out[3], 1'b0, gpio_b_out[3],
		gpio_b_out[3]);
	assign b_oe_d[3]  = pick4(fb[3], gpio_b_oe[3], 1'b0, gpio_b_oe[3],
		gpio_b_oe[3]);
	assign b_out_d[4] = pick4(fb[4], gpio_b_out[4],
		periph_out.timer0_out_inverted, 1'b0, gpio_b_out[4]);
	assign b_oe_d[4]  = pick4(fb[4], gpio_b_oe[4], go, 1'b0,
		gpio_b_oe[4]);
	assign b_out_d[5] = pick4(fb[5], gpio_b_out[5],
		periph_out.timer1_out_inverted, 1'b0, gpio_b_out[5]);
	assign b_oe_d[5]  = pick4(fb[5], gpio_b_oe[5], go, 1'b0,
		gpio_b_oe[5]);
	assign b_out_d[6] = pick4(fb[6], gpio_b_out[6], periph_out.shared_data_o,
		periph_out.peripheral_clock_out, 1'b0);
	assign b_oe_d[6]  = pick4(fb[6], gpio_b_oe[6], periph_out.shared_data_oe,
		go, 1'b0);
	assign b_out_d[7] = pick4(fb[7], gpio_b_out[7], periph_out.timer2_out,
		periph_out.serial_clock_o, 1'b0);
	assign b_oe_d[7]  = pick4(fb[7], gpio_b_oe[7], go,
		periph_out.serial_clock_oe, 1'b0);

	// Port C pad drive; reserved C3 codes fall back to GPIO
	assign c_out_d[0] = pick4(fc[0], gpio_c_out[0],
		periph_out.periodic_timer_out, periph_out.spi_slave_select_o,
		periph_out.sdo_o);
	assign c_oe_d[0]  = pick4(fc[0], gpio_c_oe[0], go,
		periph_out.spi_slave_select_oe, periph_out.sdo_oe);
	assign c_out_d[1] = pick4(fc[1], gpio_c_out[1], periph_out.timer0_out,
		periph_out.spi_slave_select_o, periph_out.sdo_o);
	assign c_oe_d[1]  = pick4(fc[1], gpio_c_oe[1], go,
		periph_out.spi_slave_select_oe, periph_out.sdo_oe);
	assign c_out_d[2] = pick4(fc[2], gpio_c_out[2], periph_out.timer1_out,
		periph_out.shared_data_o, periph_out.peripheral_clock_out);
	assign c_oe_d[2]  = pick4(fc[2], gpio_c_oe[2], go,
		periph_out.shared_data_oe, go);
	assign c_out_d[3] = pick4(fc[3], gpio_c_out[3], 1'b0, gpio_c_out[3],
		gpio_c_out[3]);
	assign c_oe_d[3]  = pick4(fc[3], gpio_c_oe[3], 1'b0, gpio_c_oe[3],
		gpio_c_oe[3]);
	assign c_out_d[4] = pick4(fc[4], gpio_c_out[4], 1'b0,
		periph_out.timer3_out, periph_out.timer_module_clock_out);
	assign c_oe_d[4]  = pick4(fc[4], gpio_c_oe[4], 1'b0, go, go);
	assign c_out_d[5] = pick4(fc[5], gpio_c_out[5],
		periph_out.peripheral_clock_out, 1'b0, gpio_c_out[5]);
	assign c_oe_d[5]  = pick4(fc[5], gpio_c_oe[5], go, 1'b0,
		gpio_c_oe[5]);
	assign c_out_d[6] = pick4(fc[6], gpio_c_out[6],
		periph_out.pwm_channel_three_out, gpio_c_out[6],
		gpio_c_out[6]);
	assign c_oe_d[6]  = pick4(fc[6], gpio_c_oe[6], go, gpio_c_oe[6],
		gpio_c_oe[6]);
	assign c_out_d[7] = pick4(fc[7], gpio_c_out[7],
		periph_out.pwm_channel_two_out, gpio_c_out[7],
		gpio_c_out[7]);
	assign c_oe_d[7]  = pick4(fc[7], gpio_c_oe[7], go, gpio_c_oe[7],
		gpio_c_oe[7]);

	// Analog switch enables
	pmx_pkg::pmx_analog_en_t ana_d;

	assign ana_d.analog_channel[0] = (fb[0] == `PMX_F2);
	assign ana_d.analog_channel[1] = fb[1][0];
	assign ana_d.analog_channel[2] = (fb[2] == `PMX_F2);
	assign ana_d.analog_channel[3] = (fb[3] == `PMX_F1);
	assign ana_d.analog_channel[4] = (fb[4] == `PMX_F2);
	assign ana_d.analog_channel[5] = (fb[5] == `PMX_F2);
	assign ana_d.analog_channel[6] = (fb[6] == `PMX_F3);
	assign ana_d.analog_channel[7] = (fb[7] == `PMX_F3);
	assign ana_d.opamp_output          = fb[1][1];
	assign ana_d.opamp_inverting_in    = (fb[0] == `PMX_F1);
	assign ana_d.adc_reference_in      = (fb[2] == `PMX_F3);
	assign ana_d.phase_detect_pb2      = (fb[2] == `PMX_F1);
	assign ana_d.phase_detect_pc5      = (fc[5] == `PMX_F2);
	assign ana_d.overvoltage_comp_in   = (fc[3] == `PMX_F1);
	assign ana_d.low_voltage_detect_in = (fc[4] == `PMX_F1);

	// Input routing from synchronised pad levels
	pmx_pkg::pmx_periph_in_t pin_d;
	wire [1:0] data_src;

	assign data_src = input_source_select_q[`PMX_IS_DATA_HI:`PMX_IS_DATA_LO];

	// Timer clocks only pass while their pin stays in GPIO mode
	assign pin_d.timer0_clock_in = (fb[2] == `PMX_F0) & pb_s2_q[2];
	assign pin_d.timer1_clock_in = (fb[3] != `PMX_F1) & pb_s2_q[3];
	assign pin_d.timer2_clock_in = (fb[4] == `PMX_F0 || fb[4] == `PMX_F3)
		& pb_s2_q[4];
	assign pin_d.timer3_clock_in = (fc[5] == `PMX_F0 || fc[5] == `PMX_F3)
		& pc_s2_q[5];
	assign pin_d.periodic_timer_clock_in = pin_d.timer3_clock_in;
	assign pin_d.periodic_capture_in = (fb[5] == `PMX_F0
		|| fb[5] == `PMX_F3) & pb_s2_q[5];
	assign pin_d.ext_irq_zero_in = input_source_select_q[`PMX_IS_IRQ0_BIT]
		? pb_s2_q[3] : pb_s2_q[4];
	assign pin_d.ext_irq_one_in = input_source_select_q[`PMX_IS_IRQ1_BIT]
		? pc_s2_q[1] : pb_s2_q[5];
	assign pin_d.jitter_freq_in = input_source_select_q[`PMX_IS_JITTER_BIT]
		? pc_s2_q[1] : pb_s2_q[5];
	assign pin_d.shared_data_in = !data_src[1] ? pa_s2_q[1] :
		(data_src[0] ? pb_s2_q[6] : pc_s2_q[2]);
	assign pin_d.serial_clock_in = input_source_select_q[`PMX_IS_SCLK_BIT]
		? pa_s2_q[0] : pb_s2_q[7];
	assign pin_d.serial_aux_in = input_source_select_q[`PMX_IS_AUX_BIT]
		? pc_s2_q[1] : pc_s2_q[0];

	// Pad synchronisers; two stages against metastability
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pb_s1_q <= 8'h00;
			pb_s2_q <= 8'h00;
			pc_s1_q <= 8'h00;
			pc_s2_q <= 8'h00;
			pa_s1_q <= 2'h0;
			pa_s2_q <= 2'h0;
		end
		else
		begin
			pb_s1_q <= pad_b_in;
			pb_s2_q <= pb_s1_q;
			pc_s1_q <= pad_c_in;
			pc_s2_q <= pc_s1_q;
			pa_s1_q <= {port_a_pin2_in, port_a_pin0_in};
			pa_s2_q <= pa_s1_q;
		end
	end

	// Output registers; costs one cycle but keeps pads glitch free
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pad_b_out_q <= 8'h00;
			pad_b_oe_q  <= 8'h00;
			pad_c_out_q <= 8'h00;
			pad_c_oe_q  <= 8'h00;
			periph_in_q <= '0;
			analog_en_q <= '0;
		end
		else
		begin
			pad_b_out_q <= b_out_d;
			pad_b_oe_q  <= b_oe_d;
			pad_c_out_q <= c_out_d;
			pad_c_oe_q  <= c_oe_d;
			periph_in_q <= pin_d;
			analog_en_q <= ana_d;
		end
	end

	// Port outputs, all straight from flip-flops
	assign pad_b_out   = pad_b_out_q;
	assign pad_b_oe    = pad_b_oe_q;
	assign pad_c_out   = pad_c_out_q;
	assign pad_c_oe    = pad_c_oe_q;
	assign periph_in   = periph_in_q;
	assign analog_en   = analog_en_q;
	assign port_b_read = pb_s2_q;
	assign port_c_read = pc_s2_q;
	assign hrdata      = hrdata_q;

	// Never stalls and never errors
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			hreadyout <= 1'b1;
			hresp     <= `PMX_HRESP_OKAY;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= `PMX_HRESP_OKAY;
		end
	end

endmodule

`default_nettype wire

// File: tb/pmx_periph_model.sv
// Far-side model: peripheral outputs and package pad levels.
// Assumes the bench pulses step to draw new levels; pads resolve drive.
`timescale 1ns/10ps
`default_nettype none

module pmx_periph_model
(
	input  wire logic                clk,
	input  wire logic                step,
	input  wire logic [7:0]          pad_b_out,
	input  wire logic [7:0]          pad_b_oe,
	input  wire logic [7:0]          pad_c_out,
	input  wire logic [7:0]          pad_c_oe,
	output pmx_pkg::pmx_periph_out_t periph_out,
	output logic [7:0]               pad_b_in,
	output logic [7:0]               pad_c_in,
	output logic                     port_a_pin0_in,
	output logic                     port_a_pin2_in
);
	logic [18:0] po_q = 19'h0;
	logic [7:0]  ext_b_q = 8'h00;
	logic [7:0]  ext_c_q = 8'h00;
	logic [1:0]  ext_a_q = 2'h0;

	// New levels only on request, so the bench can form expectations
	always_ff @(posedge clk)
		if (step)
		begin
			po_q <= 19'($urandom);
			ext_b_q <= 8'($urandom);
			ext_c_q <= 8'($urandom);
			ext_a_q <= 2'($urandom);
		end

	// A driven pad reads back its own drive, otherwise the outside level
	assign periph_out = po_q;
	assign pad_b_in = (pad_b_oe & pad_b_out) | (~pad_b_oe & ext_b_q);
	assign pad_c_in = (pad_c_oe & pad_c_out) | (~pad_c_oe & ext_c_q);
	assign port_a_pin0_in = ext_a_q[0];
	assign port_a_pin2_in = ext_a_q[1];
endmodule

`default_nettype wire

// File: tb/pmx_pin_mux_sva.sv
// Checker for the pin-function multiplexer, bound to its top ports.
// Assumes single transfers; shadows the select registers from the bus.
`timescale 1ns/10ps
`default_nettype none

module pmx_pin_mux_chk
(
	input wire logic                     clk,
	input wire logic                     nrst,
	input wire logic                     hsel,
	input wire logic [31:0]              haddr,
	input wire logic [1:0]               htrans,
	input wire logic                     hwrite,
	input wire logic [31:0]              hwdata,
	input wire logic                     hready,
	input wire logic [31:0]              hrdata,
	input wire logic [7:0]               gpio_b_out,
	input wire logic [7:0]               gpio_b_oe,
	input wire pmx_pkg::pmx_periph_out_t periph_out,
	input wire pmx_pkg::pmx_periph_in_t  periph_in,
	input wire pmx_pkg::pmx_analog_en_t  analog_en,
	input wire logic [7:0]               pad_b_in,
	input wire logic [7:0]               pad_c_in,
	input wire logic                     port_a_pin2_in,
	input wire logic [7:0]               pad_b_out,
	input wire logic [7:0]               pad_b_oe,
	input wire logic [7:0]               pad_c_out,
	input wire logic [7:0]               pad_c_oe
);
	logic       ap_q;
	logic       wr_q;
	logic [7:0] ad_q;
	logic [1:0] live_q;
	logic [7:0] sh_q [5];
	wire        take = hsel & hready & (htrans == 2'h2);
	wire        mapped = (ad_q[1:0] == 2'h0) && (ad_q[7:2] < 6'h05);
	wire  [2:0] ix = ad_q[4:2];

	// Field views of the shadow registers
	wire  [1:0] f_b0 = sh_q[0][1:0];
	wire  [1:0] f_b3 = sh_q[0][7:6];
	wire  [1:0] f_b7 = sh_q[1][7:6];
	wire  [1:0] f_c0 = sh_q[2][1:0];
	wire  [1:0] f_c6 = sh_q[3][5:4];
	wire  [1:0] f_sd = sh_q[4][3:2];
	wire        f_i1 = sh_q[4][5];

	// Shadow lands with the data phase; live_q covers the sync latency
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			ap_q <= 1'b0;
			wr_q <= 1'b0;
			ad_q <= 8'h00;
			live_q <= 2'h0;
			foreach (sh_q[i]) sh_q[i] <= 8'h00;
		end
		else
		begin
			ap_q <= take;
			wr_q <= hwrite;
			ad_q <= haddr[7:0];
			if (live_q != 2'h3) live_q <= live_q + 2'h1;
			if (ap_q && wr_q && mapped)
				sh_q[ix] <= (ix == 3'h4) ? hwdata[7:0] & 8'h7f : hwdata[7:0];
		end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_read_back: assert property (ap_q && !wr_q |->
		hrdata == {24'h0, mapped ? sh_q[ix] : 8'h00})
		else $error("read data differs from stored value");
	a_unimpl_bit: assert property (ap_q && !wr_q && ad_q == 8'h10
		|-> !hrdata[7]) else $error("input source bit 7 reads one");
	a_b3_analog: assert property (analog_en.analog_channel[3] ==
		($past(f_b3) == 2'h1)) else $error("analog 3 switch wrong");
	a_b7_timer: assert property ($past(f_b7) == 2'h1 |-> pad_b_oe[7]
		&& pad_b_out[7] == $past(periph_out.timer2_out))
		else $error("pin b7 not driven by timer 2");
	a_b0_gpio: assert property ($past(f_b0) == 2'h0 || $past(f_b0) == 2'h3
		|-> pad_b_out[0] == $past(gpio_b_out[0])
		&& pad_b_oe[0] == $past(gpio_b_oe[0]))
		else $error("pin b0 not under port control");
	a_c6_pwm: assert property ($past(f_c6) == 2'h1 |-> pad_c_oe[6]
		&& pad_c_out[6] == $past(periph_out.pwm_channel_three_out))
		else $error("pin c6 not driven by pwm 3");
	a_c0_sdo: assert property ($past(f_c0) == 2'h3 |->
		pad_c_oe[0] == $past(periph_out.sdo_oe))
		else $error("pin c0 enable not from data out");
	a_irq1_route: assert property (live_q == 2'h3 |->
		periph_in.ext_irq_one_in == ($past(f_i1) ?
		$past(pad_c_in[1], 3) : $past(pad_b_in[5], 3)))
		else $error("interrupt 1 source wrong");
	a_data_route: assert property (live_q == 2'h3 |->
		periph_in.shared_data_in == (($past(f_sd) == 2'h2) ?
		$past(pad_c_in[2], 3) : ($past(f_sd) == 2'h3) ?
		$past(pad_b_in[6], 3) : $past(port_a_pin2_in, 3)))
		else $error("shared data source wrong");

	// Main scenarios reached
	c_write: cover property (ap_q && wr_q && mapped);
	c_sclk_pin: cover property ($past(f_b7) == 2'h2);
	c_data_b6: cover property (live_q == 2'h3 && f_sd == 2'h3);
endmodule

bind pmx_pin_mux pmx_pin_mux_chk u_chk (.*);

`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the pin-function multiplexer.
// Assumes one clk domain; the far-side model supplies pad levels.
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic                     clk = 1'b0;
	logic                     nrst = 1'b0;
	logic                     hsel = 1'b0;
	logic                     hwrite = 1'b0;
	logic                     step = 1'b0;
	logic [1:0]               htrans = 2'h0;
	logic [31:0]              haddr = 32'h0;
	logic [31:0]              hwdata = 32'h0;
	logic [7:0]               gpio_b_out = 8'h00, gpio_b_oe = 8'h00;
	logic [7:0]               gpio_c_out = 8'h00, gpio_c_oe = 8'h00;
	logic                     hreadyout, hresp, port_a_pin0_in, port_a_pin2_in;
	logic [31:0]              hrdata;
	logic [7:0]               pad_b_in, pad_c_in, pad_b_out, pad_b_oe;
	logic [7:0]               pad_c_out, pad_c_oe, port_b_read, port_c_read;
	pmx_pkg::pmx_periph_out_t periph_out;
	pmx_pkg::pmx_periph_in_t  periph_in;
	pmx_pkg::pmx_analog_en_t  analog_en;
	int                       n_errors = 0;
	int                       checks = 0;
	logic [14:0]              an_t [4] =
		'{15'h0000, 15'h052b, 15'h1ac4, 15'h6150};

	// Single slave, so its ready is the bus ready
	pmx_pin_mux dut (.*, .hready(hreadyout), .hsize(3'h2));
	pmx_periph_model u_far (.*);

	initial forever #5 clk = ~clk;

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// One single transfer; read data is taken at the data-phase edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		n = 0;
		do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 99);
		r = hrdata;
		if (n >= 99) n_errors++;
	endtask

	task automatic pulse;
		step <= 1'b1;
		@(posedge clk);
		step <= 1'b0;
	endtask

	// Expected pad enables and values for every field set to code c
	function automatic logic [31:0] exp_pads(input logic [1:0] c,
		input pmx_pkg::pmx_periph_out_t p, input logic [7:0] bo, bd, co, cd);
		logic [7:0] gb, gc, boe, bq, coe, cq;
		{gb, gc, boe, bq, coe, cq} = '0;
		case (c)
		2'h0:
		begin
			gb = 8'hff;
			gc = 8'hff;
		end
		2'h1:
		begin
			boe = {1'b1, p.shared_data_oe, 6'h30};
			bq = {p.timer2_out, p.shared_data_o, p.timer1_out_inverted,
				p.timer0_out_inverted, 4'h0};
			coe = 8'he7;
			cq = {p.pwm_channel_two_out, p.pwm_channel_three_out,
				p.peripheral_clock_out, 2'h0, p.timer1_out, p.timer0_out,
				p.periodic_timer_out};
		end
		2'h2:
		begin
			gb = 8'h08;
			gc = 8'hc8;
			boe = {p.serial_clock_oe, 7'h40};
			bq = {p.serial_clock_o, p.peripheral_clock_out, 6'h0};
			coe = {4'h1, 1'b0, p.shared_data_oe, {2{p.spi_slave_select_oe}}};
			cq = {3'h0, p.timer3_out, 1'b0, p.shared_data_o,
				{2{p.spi_slave_select_o}}};
		end
		default:
		begin
			gb = 8'h39;
			gc = 8'he8;
			coe = {5'h02, 1'b1, {2{p.sdo_oe}}};
			cq = {3'h0, p.timer_module_clock_out, 1'b0,
				p.peripheral_clock_out, {2{p.sdo_o}}};
		end
		endcase
		return {(gb & bo) | boe, (gb & bd) | bq, (gc & co) | coe, (gc & cd) | cq};
	endfunction

	// Expected routed inputs in bundle order, all pins left in port mode
	function automatic logic [11:0] exp_route(input logic [7:0] s, b, c,
		input logic a0, a2);
		logic sd;
		sd = s[3:2] == 2'h2 ? c[2] : s[3:2] == 2'h3 ? b[6] : a2;
		return {b[2], b[3], b[4], c[5], c[5], b[5], s[4] ? b[3] : b[4],
			s[5] ? c[1] : b[5], s[6] ? c[1] : b[5], sd, s[1] ? a0 : b[7],
			s[0] ? c[1] : c[0]};
	endfunction

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		logic [31:0] r, d, e;
		logic [7:0]  a, s;
		logic [1:0]  cd;
		void'($urandom(32'h48ce89f0));
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		// Reset value, then random write and read back; 0x14 is unmapped
		for (int i = 0; i < 6; i++)
		begin
			a = 8'(i * 4);
			bus(1'b0, a, 32'h0, r);
			chk("reset_value", r, 32'h0);
			d = $urandom;
			if (i == 2) d[7] = 1'b0;
			bus(1'b1, a, d, r);
			bus(1'b0, a, 32'h0, r);
			chk("readback", r, i == 5 ? 32'h0 : i == 4 ? d & 32'h7f : d & 32'hff);
		end
		$display("test registers done");
		// Every pin field at one code except C3, left at 00 for codes 2 and 3; random port and peripheral levels
		for (int c = 0; c < 4; c++)
		begin
			cd = 2'(c);
			gpio_b_out <= 8'($urandom);
			gpio_b_oe <= 8'($urandom);
			gpio_c_out <= 8'($urandom);
			gpio_c_oe <= 8'($urandom);
			pulse;
			bus(1'b1, 8'h00, {24'h0, {4{cd}}}, r);
			bus(1'b1, 8'h04, {24'h0, {4{cd}}}, r);
			bus(1'b1, 8'h08, {24'h0, cd[1] ? {2'h0, {3{cd}}} : {4{cd}}}, r);
			bus(1'b1, 8'h0c, {24'h0, {4{cd}}}, r);
			repeat (2) @(posedge clk);
			#1;
			e = exp_pads(cd, periph_out, gpio_b_oe, gpio_b_out, gpio_c_oe,
				gpio_c_out);
			chk("pad_b_oe", pad_b_oe, e[31:24]);
			chk("pad_b_out", pad_b_out, e[23:16]);
			chk("pad_c_oe", pad_c_oe, e[15:8]);
			chk("pad_c_out", pad_c_out, e[7:0]);
			chk("analog", analog_en, an_t[c]);
			$display("test pin_mode %0d done", c);
		end
		// Input routing with all pins as undriven port pins
		gpio_b_oe <= 8'h00;
		gpio_c_oe <= 8'h00;
		for (int k = 0; k < 4; k++) bus(1'b1, 8'(k * 4), 32'h0, r);
		for (int k = 0; k < 8; k++)
		begin
			s = 8'($urandom) & 8'h73 | {4'h0, 2'(k), 2'h0};
			bus(1'b1, 8'h10, {24'h0, s}, r);
			pulse;
			repeat (4) @(posedge clk);
			#1;
			chk("routed", periph_in, exp_route(s, pad_b_in, pad_c_in,
				port_a_pin0_in, port_a_pin2_in));
			chk("port_read", {port_b_read, port_c_read}, {pad_b_in, pad_c_in});
		end
		$display("test routing done");
		conclude;
	end

	// Cuts a hang short well past the expected run length
	initial
	begin
		#20000;
		n_errors++;
		conclude;
	end
endmodule

`default_nettype wire
